// file: design/flash_map_defs.vh
/*
 * Constants for the flash array map decoder: global address windows,
 * array geometry, configuration field layout and register offsets.
 * Assumes a 23-bit global address and a 32-bit APB register bus.
 */
`ifndef FLASH_MAP_DEFS_VH
`define FLASH_MAP_DEFS_VH

// ****************************************************************
// Global address windows
// ****************************************************************
`define PROG_BASE        23'h7c0000
`define PROG_TOP         23'h7fffff
`define PROG_LOWER_BASE  23'h7f8000
`define CFG_KEY_BASE     23'h7fff00
`define CFG_RSV_BASE     23'h7fff08
`define CFG_PROGRAM_ARRAY_PROTECT_BYTE_ADDR   23'h7fff0c
`define CFG_DPROT_ADDR   23'h7fff0d
`define CFG_OPT_ADDR     23'h7fff0e
`define CFG_SEC_ADDR     23'h7fff0f
`define PINFO_BASE       23'h400000
`define PINFO_TOP        23'h4001ff
`define PINFO_DEVID      23'h400000
`define PINFO_VERID      23'h4000e8
`define PINFO_ONCE       23'h400100
`define DATA_BASE        23'h100000
`define DATA_TOP         23'h101fff
`define DINFO_BASE       23'h120000
`define DINFO_TOP        23'h12007f
`define SRAM_BASE        23'h123d00
`define SRAM_TOP         23'h123fff

// ****************************************************************
// Geometry
// ****************************************************************
`define PROG_SECTOR_BYTES 1024
`define PROG_SECTORS      256
`define DATA_SECTOR_BYTES 256
`define DATA_ROW_BYTES    64
`define DATA_SECTORS      32
`define DATA_BURST_MAX    3'd4
`define ERASED_WORD       16'hffff
`define RSV_BYTE          8'hff

// ****************************************************************
// Region select codes
// ****************************************************************
`define RGN_NONE  3'd0
`define RGN_PROG  3'd1
`define RGN_PINFO 3'd2
`define RGN_DATA  3'd3
`define RGN_DINFO 3'd4
`define RGN_SRAM  3'd5

// ****************************************************************
// APB register offsets and fields
// ****************************************************************
`define REG_MAPCTL   12'h000
`define REG_CMD      12'h004
`define REG_ADDR     12'h008
`define REG_WDATA    12'h00c
`define REG_STATUS   12'h010
`define REG_RDATA    12'h014
`define MAP_PINFO_BIT 0
`define MAP_DINFO_BIT 1
`define MAP_SRAM_BIT  2
`define CMD_READ     2'd0
`define CMD_PROGRAM  2'd1
`define CMD_ERASE    2'd2
`define ALGO_CYCLES  8'd16

`endif

// file: design/secded_word.v
/*
 * Single-error-correct, double-error-detect code over one 16-bit word.
 * Encoding is purely combinational; the caller registers the results.
 */
`timescale 1ns/100ps
module secded_word
(
    input  wire [15:0] data_in,
    input  wire [5:0]  check_in,
    output reg  [5:0]  check_out,
    output reg  [15:0] data_fix,
    output reg         single_err,
    output reg         double_err
);
    // Hamming positions 1..21 with overall parity in bit 5.
    reg [21:1] cw;
    reg [4:0]  syn;
    reg        ovr;
    integer    i;
    integer    k;

    always @*
    begin
        cw = 21'd0;
        k = 0;
        for (i = 1; i <= 21; i = i + 1)
        begin
            if ((i & (i - 1)) != 0)
            begin
                cw[i] = data_in[k];
                k = k + 1;
            end
        end
        check_out = 6'd0;
        for (i = 1; i <= 21; i = i + 1)
        begin
            if (i[0]) check_out[0] = check_out[0] ^ cw[i];
            if (i[1]) check_out[1] = check_out[1] ^ cw[i];
            if (i[2]) check_out[2] = check_out[2] ^ cw[i];
            if (i[3]) check_out[3] = check_out[3] ^ cw[i];
            if (i[4]) check_out[4] = check_out[4] ^ cw[i];
        end
        check_out[5] = ^{cw, check_out[4:0]};
        syn = check_out[4:0] ^ check_in[4:0];
        ovr = check_out[5] ^ check_in[5] ^ (^syn);
        single_err = ovr;
        double_err = (syn != 5'd0) && !ovr;
        data_fix = data_in;
        k = 0;
        for (i = 1; i <= 21; i = i + 1)
        begin
            if ((i & (i - 1)) != 0)
            begin
                if (ovr && (syn == i[4:0]))
                    data_fix[k] = ~data_in[k];
                k = k + 1;
            end
        end
    end
endmodule

// file: design/flash_word_mem.v
/*
 * Word memory with registered read data standing in for an array.
 * Assumes a single clock; contents are not reset.
 */
`timescale 1ns/100ps
module flash_word_mem
#(
    parameter AW = 8,
    parameter DW = 22
)
(
    input  wire          mclk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge mclk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule

// file: design/flash_array_map_decode.v
/*
 * Flash array map decoder: decodes global addresses into region selects,
 * holds window enables, protection and a small modelled array with
 * per-word error correction, program and erase commands over APB.
 * Assumes an APB master on mclk and an on-chip address bus on mclk.
 */
// What this block does
// - Data array erases whole 256-byte sectors of four 64-byte rows.
// - Program array is organised in 16-bit words with check bits.
// - Program reads correct single and detect double errors per 16-bit word.
// - Program array holds 256 erase sectors of 1024 bytes.
// - Data array holds 8 Kbytes in 32 sectors of 256 bytes.
// - Data reads correct single and detect double errors per word.
// - Program runs automatically with verify; program and erase make own check bits.
// - Data programming takes a burst of up to four words.
// - Program information window shows only while its enable is set.
// - Writes to unimplemented space are ignored; such reads are undefined.
// - Program array maps onto 0x7C0000 through 0x7FFFFF.
// - Protection of lower and higher program regions stays disabled: its byte keeps reset value 0xFF.
// - Configuration field holds key, reserved bytes and four option bytes.
// - Information window holds device id, version id and program-once field.
// - Data array at 0x100000; data information row only when enabled.
// - Scratch RAM at 0x123D00 to 0x123FFF only when enabled.
// - Command completion and detected errors can raise an interrupt.
// - No off-chip pins; all traffic uses internal buses.
// - Erased cells read one, programmed cells read zero.
`timescale 1ns/100ps
`include "flash_map_defs.vh"
module flash_array_map_decode
#(
    parameter [15:0] DEVICE_ID_WORD = 16'h5a5a // Arbitrary value.
)
(
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [22:0] gaddr,
    input  wire        gvalid,
    input  wire        gwrite,
    output reg  [2:0]  region_sel,
    output reg         lower_prot_hit,
    output reg         higher_prot_hit,
    output reg         write_dropped,
    output reg         irq
);
    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function [2:0] decode_region;
        input [22:0] a;
        input [2:0]  en;
        begin
            if (a >= `PROG_BASE)
                decode_region = `RGN_PROG;
            else if (a >= `PINFO_BASE && a <= `PINFO_TOP && en[`MAP_PINFO_BIT])
                decode_region = `RGN_PINFO;
            else if (a >= `DATA_BASE && a <= `DATA_TOP)
                decode_region = `RGN_DATA;
            else if (a >= `DINFO_BASE && a <= `DINFO_TOP && en[`MAP_DINFO_BIT])
                decode_region = `RGN_DINFO;
            else if (a >= `SRAM_BASE && a <= `SRAM_TOP && en[`MAP_SRAM_BIT])
                decode_region = `RGN_SRAM;
            else
                decode_region = `RGN_NONE;
        end
    endfunction

    // Protection byte: bit5 higher disable, 4:3 higher size, bit2 lower
    // disable, 1:0 lower size, bit7 open. Sizes double from 2K (higher)
    // and 1K (lower).
    function [1:0] prot_hit;
        input [22:0] a;
        input [7:0]  p;
        reg   [22:0] hsz;
        reg   [22:0] lsz;
        begin
            hsz = 23'h000800 << p[4:3];
            lsz = 23'h000400 << p[1:0];
            prot_hit[1] = (a >= `PROG_BASE) && !p[5] && (a > (`PROG_TOP - hsz));
            prot_hit[0] = !p[2] && (a >= `PROG_LOWER_BASE)
                          && (a < (`PROG_LOWER_BASE + lsz));
        end
    endfunction

    // ****************************************************************
    // State and registers
    // ****************************************************************
    localparam ST_IDLE  = 2'd0;
    localparam ST_READ  = 2'd1;
    localparam ST_PROG  = 2'd2;
    localparam ST_ERASE = 2'd3;

    reg [2:0]  map_control_reg_one_reg;
    reg [7:0]  program_array_protect_byte_reg;
    reg [7:0]  data_array_protect_byte_reg;
    reg [7:0]  nonvolatile_option_byte_reg;
    reg [7:0]  security_byte_reg;
    reg [22:0] cmd_addr_reg;
    reg [63:0] wdata_reg;
    reg [2:0]  burst_reg;
    reg [2:0]  burst_idx_reg;
    reg [1:0]  state_reg;
    reg [7:0]  algo_cnt_reg;
    reg [8:0]  erase_idx_reg;
    reg [15:0] rdata_reg;
    reg        done_flag_reg;
    reg        sbe_flag_reg;
    reg        dbe_flag_reg;
    reg        acc_err_reg;
    reg        done_ie_reg;
    reg        err_ie_reg;
    reg        verify_fail_reg;
    reg        rd_wait_reg;

    wire [15:0] wr_word;
    wire [5:0]  wr_check;
    wire [21:0] mem_rdata;
    wire [15:0] fix_word;
    wire        sbe;
    wire        dbe;
    wire [5:0]  unused_check;
    wire        bus_wr;
    wire        bus_rd;
    wire [1:0]  cmd_prot;
    wire [2:0]  cmd_rgn;
    reg         mem_we;
    reg  [7:0]  mem_waddr;
    reg  [21:0] mem_wdata;
    reg  [7:0]  mem_raddr;

    assign bus_wr = psel && penable && pwrite;
    assign bus_rd = psel && penable && !pwrite;
    assign wr_word = wdata_reg[16*burst_idx_reg[1:0] +: 16];
    assign cmd_prot = prot_hit(cmd_addr_reg, program_array_protect_byte_reg);
    assign cmd_rgn = decode_region(cmd_addr_reg, map_control_reg_one_reg);

    // Encoder for words being programmed; check bits are made here.
    secded_word u_enc
    (
        .data_in    (wr_word),
        .check_in   (6'd0),
        .check_out  (wr_check),
        .data_fix   (),
        .single_err (),
        .double_err ()
    );

    // Checker on words read back from the array.
    secded_word u_dec
    (
        .data_in    (mem_rdata[15:0]),
        .check_in   (mem_rdata[21:16]),
        .check_out  (unused_check),
        .data_fix   (fix_word),
        .single_err (sbe),
        .double_err (dbe)
    );

    flash_word_mem #(.AW(8), .DW(22)) u_mem
    (
        .mclk  (mclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ****************************************************************
    // Array port steering
    // ****************************************************************
    always @*
    begin
        mem_we = 1'b0;
        mem_waddr = cmd_addr_reg[8:1] + {5'd0, burst_idx_reg};
        mem_wdata = {wr_check, wr_word};
        mem_raddr = cmd_addr_reg[8:1];
        if (state_reg == ST_PROG && algo_cnt_reg == 8'd0)
            mem_we = 1'b1;
        if (state_reg == ST_ERASE)
        begin
            mem_we = 1'b1;
            mem_waddr = erase_idx_reg[7:0];
            // Erased cells read as ones; the matching check bits keep
            // the erased word free of reported errors.
            mem_wdata = {6'h1e, `ERASED_WORD};
        end
        if (state_reg == ST_PROG && algo_cnt_reg == 8'd1)
            mem_raddr = mem_waddr;
    end

    // ****************************************************************
    // Address-bus decode, registered
    // ****************************************************************
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            region_sel <= `RGN_NONE;
            lower_prot_hit <= 1'b0;
            higher_prot_hit <= 1'b0;
            write_dropped <= 1'b0;
        end
        else
        begin
            region_sel <= gvalid ? decode_region(gaddr, map_control_reg_one_reg)
                                 : `RGN_NONE;
            {higher_prot_hit, lower_prot_hit} <= gvalid
                ? prot_hit(gaddr, program_array_protect_byte_reg) : 2'b00;
            write_dropped <= gvalid && gwrite
                && (decode_region(gaddr, map_control_reg_one_reg) == `RGN_NONE);
        end
    end

    // ****************************************************************
    // APB slave and command engine
    // ****************************************************************
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            map_control_reg_one_reg <= 3'd0;
            program_array_protect_byte_reg <= `RSV_BYTE;
            data_array_protect_byte_reg <= `RSV_BYTE;
            nonvolatile_option_byte_reg <= `RSV_BYTE;
            security_byte_reg <= `RSV_BYTE;
            cmd_addr_reg <= 23'd0;
            wdata_reg <= 64'd0;
            burst_reg <= 3'd1;
            burst_idx_reg <= 3'd0;
            state_reg <= ST_IDLE;
            algo_cnt_reg <= 8'd0;
            erase_idx_reg <= 9'd0;
            rdata_reg <= 16'd0;
            done_flag_reg <= 1'b1;
            sbe_flag_reg <= 1'b0;
            dbe_flag_reg <= 1'b0;
            acc_err_reg <= 1'b0;
            done_ie_reg <= 1'b0;
            err_ie_reg <= 1'b0;
            verify_fail_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            prdata <= 32'd0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            irq <= (done_flag_reg && done_ie_reg)
                   || ((sbe_flag_reg || dbe_flag_reg) && err_ie_reg);
            if (bus_rd && !pready)
            begin
                case (paddr)
                    `REG_MAPCTL: prdata <= {29'd0, map_control_reg_one_reg};
                    `REG_CMD:    prdata <= {program_array_protect_byte_reg,
                                            data_array_protect_byte_reg,
                                            nonvolatile_option_byte_reg,
                                            security_byte_reg};
                    `REG_ADDR:   prdata <= {9'd0, cmd_addr_reg};
                    `REG_WDATA:  prdata <= wdata_reg[31:0];
                    `REG_STATUS: prdata <= {24'd0, err_ie_reg, done_ie_reg,
                                            verify_fail_reg, acc_err_reg,
                                            dbe_flag_reg, sbe_flag_reg,
                                            state_reg == ST_IDLE, done_flag_reg};
                    `REG_RDATA:  prdata <= {16'd0, rdata_reg};
                    default:     prdata <= 32'd0;
                endcase
                pslverr <= (paddr > `REG_RDATA) || (paddr[1:0] != 2'b00);
            end
            if (bus_wr && pready)
            begin
                case (paddr)
                    `REG_MAPCTL: map_control_reg_one_reg <= pwdata[2:0];
                    `REG_ADDR:   cmd_addr_reg <= pwdata[22:0];
                    `REG_WDATA:  wdata_reg <= {wdata_reg[31:0], pwdata};
                    `REG_STATUS:
                    begin
                        done_ie_reg <= pwdata[7];
                        err_ie_reg <= pwdata[6];
                        // Write one to clear; a same-cycle event wins below.
                        if (pwdata[2]) sbe_flag_reg <= 1'b0;
                        if (pwdata[3]) dbe_flag_reg <= 1'b0;
                        if (pwdata[4]) acc_err_reg <= 1'b0;
                    end
                    `REG_CMD:
                    begin
                        if (state_reg == ST_IDLE)
                        begin
                            done_flag_reg <= 1'b0;
                            verify_fail_reg <= 1'b0;
                            algo_cnt_reg <= 8'd0;
                            burst_idx_reg <= 3'd0;
                            burst_reg <= (pwdata[4:2] == 3'd0 || pwdata[4:2] > `DATA_BURST_MAX)
                                         ? 3'd1 : pwdata[4:2];
                            case (pwdata[1:0])
                                `CMD_READ:
                                begin
                                    state_reg <= ST_READ;
                                    algo_cnt_reg <= 8'd1;
                                end
                                `CMD_PROGRAM:
                                    if (cmd_prot != 2'b00 && cmd_rgn == `RGN_PROG)
                                    begin
                                        acc_err_reg <= 1'b1;
                                        done_flag_reg <= 1'b1;
                                    end
                                    else
                                        state_reg <= ST_PROG;
                                `CMD_ERASE:
                                begin
                                    state_reg <= ST_ERASE;
                                    // Data sectors are 256 bytes, 128 model words;
                                    // program sectors of 1024 bytes also erase only 128 model words.
                                    erase_idx_reg <= {1'b0, cmd_addr_reg[8:8], 7'd0};
                                end
                                default:
                                begin
                                    acc_err_reg <= 1'b1;
                                    done_flag_reg <= 1'b1;
                                end
                            endcase
                        end
                        else
                            acc_err_reg <= 1'b1;
                    end
                    default: ;
                endcase
            end
            case (state_reg)
                ST_IDLE: ;
                ST_READ:
                begin
                    if (algo_cnt_reg != 8'd0)
                        algo_cnt_reg <= algo_cnt_reg - 8'd1;
                    else
                    begin
                        rdata_reg <= (cmd_rgn == `RGN_PINFO && cmd_addr_reg[8:3] == 6'd0)
                                     ? DEVICE_ID_WORD : fix_word;
                        if (sbe) sbe_flag_reg <= 1'b1;
                        if (dbe) dbe_flag_reg <= 1'b1;
                        done_flag_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_PROG:
                begin
                    if (algo_cnt_reg == 8'd0)
                        algo_cnt_reg <= 8'd1;
                    else if (algo_cnt_reg == 8'd1)
                        algo_cnt_reg <= 8'd2;
                    else if (algo_cnt_reg == 8'd2)
                    begin
                        // Verify the word just written.
                        if (mem_rdata[15:0] != wr_word)
                            verify_fail_reg <= 1'b1;
                        if (burst_idx_reg + 3'd1 >= burst_reg)
                        begin
                            done_flag_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            burst_idx_reg <= burst_idx_reg + 3'd1;
                            algo_cnt_reg <= 8'd0;
                        end
                    end
                    else
                        algo_cnt_reg <= algo_cnt_reg - 8'd1;
                end
                ST_ERASE:
                begin
                    if (erase_idx_reg[6:0] == 7'h7f)
                    begin
                        done_flag_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    erase_idx_reg <= erase_idx_reg + 9'd1;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: test/flash_map_checker.sv
/* Assertions on the ports of the flash map decoder.
   Assumes it is bound into the decoder and sees its clock and reset. */
`timescale 1ns/100ps
module flash_map_checker
(
    input wire        mclk,
    input wire        rst_n,
    input wire [22:0] gaddr,
    input wire        gvalid,
    input wire        gwrite,
    input wire [2:0]  region_sel,
    input wire        lower_prot_hit,
    input wire        higher_prot_hit,
    input wire        write_dropped
);
// ************************************************
// Decode checks
// ************************************************
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_n);
AST_PROG_MAP:
    assert property (gvalid && gaddr >= 23'h7c0000 |=> region_sel == 3'd1) else $error("prog map");
AST_DATA_MAP:
    assert property (gvalid && gaddr inside {[23'h100000:23'h101fff]} |=> region_sel == 3'd3)
        else $error("data map");
AST_RSV_DROP:
    assert property (gvalid && gaddr inside {[23'h102000:23'h11ffff]}
        |=> region_sel == 3'd0 && write_dropped == $past(gwrite)) else $error("reserved space");
AST_PINFO_WIN:
    assert property (region_sel == 3'd2 |-> $past(gaddr) inside {[23'h400000:23'h4001ff]})
        else $error("prog info window");
AST_DINFO_WIN:
    assert property (region_sel == 3'd4 |-> $past(gvalid) && $past(gaddr) inside
        {[23'h120000:23'h12007f]}) else $error("data info window");
AST_SRAM_WIN:
    assert property (region_sel == 3'd5 |-> $past(gaddr) inside {[23'h123d00:23'h123fff]})
        else $error("scratch window");
AST_LOWER_PROT:
    assert property (lower_prot_hit |-> $past(gaddr) >= 23'h7f8000) else $error("lower region");
AST_HIGHER_PROT:
    assert property (higher_prot_hit |-> region_sel == 3'd1 && $past(gaddr) >= 23'h7f8000)
        else $error("higher region");
cover property (region_sel == 3'd5);
cover property (region_sel == 3'd2);
cover property (write_dropped);
endmodule
bind flash_array_map_decode flash_map_checker flash_map_checker_inst (.mclk, .rst_n, .gaddr,
    .gvalid, .gwrite, .region_sel, .lower_prot_hit, .higher_prot_hit, .write_dropped);

// file: test/bus_probe_master.sv
/* Model of the on-chip bus master presenting global addresses.
   Assumes the decoder clock; one sample per call of probe. */
`timescale 1ns/100ps
module bus_probe_master
(
    input  wire         mclk,
    output logic [22:0] gaddr = 23'h0,
    output logic        gvalid = 1'b0,
    output logic        gwrite = 1'b0
);
// ************************************************
// Probe task
// ************************************************
task probe(input logic [22:0] a, input logic w);
    @(posedge mclk);
    gaddr  <= a;
    gvalid <= 1'b1;
    gwrite <= w;
    @(posedge mclk);
    gvalid <= 1'b0;
    // A released bus shows no stale address.
    gaddr  <= ~a;
    gwrite <= ~w;
endtask
endmodule

// file: test/flash_array_map_decode_test.sv
/* Self-checking bench for the flash map decoder.
   Assumes the probe master model and the bound checker. */
`timescale 1ns/100ps
module flash_array_map_decode_test;
// ************************************************
// Bench
// ************************************************
logic        mclk = 1'b0;
logic        rst_n = 1'b0;
logic        psel = 1'b0;
logic        penable = 1'b0;
logic        pwrite = 1'b0;
logic [11:0] paddr = 12'h0;
logic [31:0] pwdata = 32'h0;
wire  [31:0] prdata;
wire         pready;
wire         pslverr;
wire  [22:0] gaddr;
wire         gvalid;
wire         gwrite;
wire  [2:0]  region_sel;
wire         irq;
int          miscompares = 0;
int          checks = 0;
int          cyc = 0;
logic [32:0] exp_q[$];
logic [32:0] msk_q[$];
logic [2:0]  rgn_q[$];
logic [1:0]  gv_d = 2'b0;
logic [31:0] rd;
logic [22:0] a;
logic [63:0] q;
logic [22:0] pa[12] = '{23'h7c0000, 23'h7fffff, 23'h400000, 23'h4001ff, 23'h100000,
    23'h101fff, 23'h102000, 23'h120000, 23'h12007f, 23'h120080, 23'h123d00, 23'h123fff};
logic [2:0]  pr[12] = '{3'd1, 3'd1, 3'd2, 3'd2, 3'd3, 3'd3, 3'd0, 3'd4, 3'd4, 3'd0, 3'd5, 3'd5};
always #20 mclk = ~mclk;
flash_array_map_decode flash_array_map_decode_inst (.mclk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .gaddr, .gvalid, .gwrite, .region_sel,
    .lower_prot_hit(), .higher_prot_hit(), .write_dropped(), .irq);
bus_probe_master bus_probe_master_inst (.mclk, .gaddr, .gvalid, .gwrite);
task check(input string n, input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e)
    begin
        miscompares++;
        $display("wrong value %s expected %h seen %h", n, e, s);
    end
endtask
task wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] e, m);
    if (!w)
    begin
        exp_q.push_back(e);
        msk_q.push_back(m);
    end
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
        @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
endtask
task run(input logic [31:0] c);
    apb(1'b1, 12'h004, c, 33'h0, 33'h0);
    rd = 32'h0;
    while (rd[0] !== 1'b1)
        apb(1'b0, 12'h010, 32'h0, 33'h0, 33'h0);
endtask
always @(posedge mclk)
begin
    gv_d <= {gv_d[0], gvalid};
    cyc++;
    if (cyc == 20000)
    begin
        miscompares++;
        wrap_up;
    end
end
// Results are compared at the falling edge, once the registered outputs have settled.
always @(negedge mclk)
begin
    if (pready === 1'b1 && pwrite === 1'b0)
    begin
        if (msk_q[0] != 33'h0)
            check("read", {pslverr, prdata} & msk_q[0], exp_q[0]);
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
    end
    if (gv_d[0])
        check("region", {30'h0, region_sel}, {30'h0, rgn_q.pop_front()});
end
initial
begin
    void'($urandom(32'hac54dbe3));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 33'h0, 33'h1_0000_0007);
    apb(1'b0, 12'h004, 32'h0, 33'h0_ffff_ffff, 33'h1_ffff_ffff);
    apb(1'b0, 12'hffc, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
    apb(1'b1, 12'h000, 32'h7, 33'h0, 33'h0);
    apb(1'b0, 12'h000, 32'h0, 33'h7, 33'h1_0000_0007);
    apb(1'b1, 12'h010, 32'h80, 33'h0, 33'h0);
    repeat (2) @(negedge mclk);
    check("irq", {32'h0, irq}, 33'h1);
    for (int k = 0; k < 2; k++)
    begin
        foreach (pa[i])
        begin
            rgn_q.push_back(k && pr[i] inside {3'd2, 3'd4, 3'd5} ? 3'd0 : pr[i]);
            bus_probe_master_inst.probe(pa[i], k[0]);
        end
        rgn_q.push_back(3'd3);
        bus_probe_master_inst.probe(23'h100000 | (23'($urandom) & 23'h1fff), k[0]);
        apb(1'b1, 12'h000, 32'h0, 33'h0, 33'h0);
    end
    a = 23'h100000 | (23'($urandom) & 23'h1f8);
    q = {$urandom, $urandom};
    for (int p = 0; p < 2; p++)
    begin
        if (p)
        begin
            apb(1'b1, 12'h00c, q[63:32], 33'h0, 33'h0);
            apb(1'b1, 12'h00c, q[31:0], 33'h0, 33'h0);
        end
        apb(1'b1, 12'h008, {9'h0, a}, 33'h0, 33'h0);
        run(p ? 32'h11 : 32'h6);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, 12'h008, {9'h0, a + 23'(2 * k)}, 33'h0, 33'h0);
            run(32'h4);
            check("status", {29'h0, rd[5:2]}, 33'h0);
            apb(1'b0, 12'h014, 32'h0, {17'h0, p ? q[16 * k +: 16] : 16'hffff},
                33'h1_0000_ffff);
        end
    end
    wrap_up;
end
endmodule
